// File: verilog/ims_sequencer.v
// motion sequencer: command queue, homing, continuous velocity, waits
`timescale 1ns/100ps
`default_nettype none
`include "ims_defines.vh"

module ims_sequencer #(
  parameter integer VEL_W      = 16,
  parameter integer POS_W      = 32,
  parameter integer NTRIG      = 6,
  parameter integer SECOND_CYC = `IMS_SECOND_CYC,
  parameter integer RAMP_CYC   = `IMS_RAMP_CYC
) (
  input  wire                  clk_i,
  input  wire                  rst_n_i,
  input  wire                  cmd_valid_i,
  input  wire [`IMS_OP_W-1:0]  cmd_op_i,
  input  wire [VEL_W-1:0]      cmd_arg_i,
  input  wire [2*NTRIG-1:0]    cmd_pattern_i,
  output reg                   cmd_ready_o,
  input  wire                  home_n_i,
  input  wire                  cw_limit_n_i,
  input  wire                  ccw_limit_n_i,
  input  wire [NTRIG-1:0]      trig_n_i,
  output reg                   step_o,
  output reg                   dir_o,
  output reg  [VEL_W-1:0]      velocity_o,
  output reg  [POS_W-1:0]      position_o,
  output reg  [POS_W-1:0]      home_pos_o,
  output reg                   moving_o,
  output reg                   waiting_o,
  output reg                   homed_o
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [NTRIG+2:0] in_meta_r;
  reg [NTRIG+2:0] in_sync_r;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_meta_r <= {(NTRIG+3){1'b1}};
      in_sync_r <= {(NTRIG+3){1'b1}};
    end else begin
      in_meta_r <= {trig_n_i, ccw_limit_n_i, cw_limit_n_i, home_n_i};
      in_sync_r <= in_meta_r;
    end
  end
  wire             home_act = ~in_sync_r[0];
  wire             cw_act   = ~in_sync_r[1];
  wire             ccw_act  = ~in_sync_r[2];
  wire [NTRIG-1:0] trig_act = ~in_sync_r[NTRIG+2:3];

  // ---------------------------------------------------------------
  // command queue
  // ---------------------------------------------------------------
  localparam integer QW = `IMS_OP_W + VEL_W + 2*NTRIG;
  reg [QW-1:0]              q_mem [0:`IMS_QUEUE_DEPTH-1];
  reg [`IMS_QUEUE_AW-1:0]   wp_r;
  reg [`IMS_QUEUE_AW-1:0]   rp_r;
  reg [`IMS_QUEUE_AW:0]     cnt_r;
  reg                       hold_r;
  reg                       limit_en_r;

  // stop and kill bypass the queue
  wire imm = cmd_op_i == `IMS_OP_STOP || cmd_op_i == `IMS_OP_KILL ||
             cmd_op_i == `IMS_OP_HOLD_QUEUE ||
             cmd_op_i == `IMS_OP_CONTINUE;
  wire push = cmd_valid_i && cmd_ready_o && !imm;
  wire abort = cmd_valid_i && cmd_ready_o &&
               (cmd_op_i == `IMS_OP_STOP || cmd_op_i == `IMS_OP_KILL);

  // ---------------------------------------------------------------
  // executor state
  // ---------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_FETCH = 6'h02;
  localparam [5:0] S_HOME  = 6'h04;
  localparam [5:0] S_DECEL = 6'h08;
  localparam [5:0] S_TWAIT = 6'h10;
  localparam [5:0] S_IWAIT = 6'h20;
  reg [5:0]         st_r;
  reg [VEL_W-1:0]   vel_set_r;
  reg [VEL_W-1:0]   accel_r;
  reg [VEL_W-1:0]   target_r;
  reg               cont_r;
  reg [VEL_W-1:0]   twait_sec_r;
  reg [31:0]        tick_r;
  reg [2*NTRIG-1:0] pat_r;
  reg [VEL_W+7:0]   phase_r;
  reg [31:0]        ramp_div_r;

  wire [QW-1:0]          head   = q_mem[rp_r];
  wire [`IMS_OP_W-1:0]   h_op   = head[QW-1 -: `IMS_OP_W];
  wire [VEL_W-1:0]       h_arg  = head[2*NTRIG +: VEL_W];
  wire [2*NTRIG-1:0]     h_pat  = head[2*NTRIG-1:0];
  wire pop = st_r == S_FETCH && cnt_r != 0 && !hold_r;

  // pattern pair per input, 2'b01 means must be on, else ignore
  function pat_ok;
    input [2*NTRIG-1:0] pat;
    input [NTRIG-1:0]   act;
    integer k;
    begin
      pat_ok = 1'b1;
      for (k = 0; k < NTRIG; k = k + 1)
        if (pat[2*k +: 2] == 2'b01 && !act[k])
          pat_ok = 1'b0;
    end
  endfunction

  // trigger three steers as a limit until disabled
  wire trig_lim = limit_en_r && trig_act[`IMS_LIMIT_TRIG];
  // dedicated limit inputs always stop motion toward them
  wire lim_hit = (dir_o ? cw_act : ccw_act) || trig_lim;
  wire at_speed = velocity_o == target_r;
  wire ramp_tick = ramp_div_r == RAMP_CYC - 1;
  wire [VEL_W+7:0] phase_nxt = phase_r + {8'h00, velocity_o};

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= {`IMS_QUEUE_AW{1'b0}};
      rp_r <= {`IMS_QUEUE_AW{1'b0}};
      cnt_r <= {(`IMS_QUEUE_AW+1){1'b0}};
      hold_r <= 1'b0;
      limit_en_r <= 1'b1;
      cmd_ready_o <= 1'b0;
      st_r <= S_IDLE;
      vel_set_r <= {VEL_W{1'b0}};
      accel_r <= {{(VEL_W-1){1'b0}}, 1'b1};
      target_r <= {VEL_W{1'b0}};
      cont_r <= 1'b0;
      twait_sec_r <= {VEL_W{1'b0}};
      tick_r <= 32'h0000_0000;
      pat_r <= {(2*NTRIG){1'b0}};
      phase_r <= {(VEL_W+8){1'b0}};
      ramp_div_r <= 32'h0000_0000;
      step_o <= 1'b0;
      dir_o <= 1'b1;
      velocity_o <= {VEL_W{1'b0}};
      position_o <= {POS_W{1'b0}};
      home_pos_o <= {POS_W{1'b0}};
      moving_o <= 1'b0;
      waiting_o <= 1'b0;
      homed_o <= 1'b0;
    end else begin
      cmd_ready_o <= cnt_r < `IMS_QUEUE_DEPTH - 1;
      if (push) begin
        q_mem[wp_r] <= {cmd_op_i, cmd_arg_i, cmd_pattern_i};
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {{`IMS_QUEUE_AW{1'b0}}, push}
                     - {{`IMS_QUEUE_AW{1'b0}}, pop};
      if (cmd_valid_i && cmd_ready_o && cmd_op_i == `IMS_OP_HOLD_QUEUE)
        hold_r <= 1'b1;
      if (cmd_valid_i && cmd_ready_o && cmd_op_i == `IMS_OP_CONTINUE)
        hold_r <= 1'b0;

      // ramp toward target at the latest acceleration rate
      ramp_div_r <= ramp_tick ? 32'h0000_0000 : ramp_div_r + 32'h0000_0001;
      // differences taken in order so a large rate never wraps
      if (ramp_tick) begin
        if (velocity_o < target_r)
          velocity_o <= (target_r - velocity_o > accel_r) ?
                        velocity_o + accel_r : target_r;
        else if (velocity_o > target_r)
          velocity_o <= (velocity_o - target_r > accel_r) ?
                        velocity_o - accel_r : target_r;
      end
      phase_r <= phase_nxt;
      step_o <= phase_nxt[VEL_W+7] != phase_r[VEL_W+7];
      if (step_o)
        position_o <= dir_o ? position_o + 1'b1 : position_o - 1'b1;
      moving_o <= velocity_o != {VEL_W{1'b0}};

      case (st_r)
        S_IDLE: begin
          st_r <= S_FETCH;
        end
        S_FETCH: begin
          waiting_o <= 1'b0;
          if (pop) begin
            case (h_op)
              `IMS_OP_SEEK_HOME: begin
                // constant velocity seek in commanded direction
                dir_o <= h_pat[0];
                target_r <= h_arg;
                homed_o <= 1'b0;
                st_r <= S_HOME;
              end
              `IMS_OP_CONT_MODE: cont_r <= 1'b1;
              `IMS_OP_VELOCITY: vel_set_r <= h_arg;
              `IMS_OP_ACCEL: accel_r <= h_arg;
              `IMS_OP_LIMIT_DIS: limit_en_r <= 1'b0;
              // in continuous mode go ramps to last setpoint; no stop in between
              `IMS_OP_GO: if (cont_r) target_r <= vel_set_r;
              `IMS_OP_TIME_WAIT: begin
                twait_sec_r <= h_arg;
                tick_r <= 32'h0000_0000;
                waiting_o <= 1'b1;
                st_r <= S_TWAIT;
              end
              `IMS_OP_INPUT_WAIT: begin
                pat_r <= h_pat;
                waiting_o <= 1'b1;
                st_r <= S_IWAIT;
              end
              default: st_r <= S_FETCH;
            endcase
          end
        end
        S_HOME: begin
          if (home_act) begin
            home_pos_o <= position_o;
            target_r <= {VEL_W{1'b0}};
            st_r <= S_DECEL;
          end else if (lim_hit) begin
            target_r <= {VEL_W{1'b0}};
            velocity_o <= {VEL_W{1'b0}};
            st_r <= S_FETCH;
          end
        end
        S_DECEL: begin
          if (velocity_o == {VEL_W{1'b0}}) begin
            position_o <= {POS_W{1'b0}};
            homed_o <= 1'b1;
            st_r <= S_FETCH;
          end
        end
        S_TWAIT: begin
          // count only once constant velocity is reached
          if (at_speed) begin
            if (twait_sec_r == {VEL_W{1'b0}})
              st_r <= S_FETCH;
            else if (tick_r == SECOND_CYC - 1) begin
              tick_r <= 32'h0000_0000;
              twait_sec_r <= twait_sec_r - 1'b1;
            end else
              tick_r <= tick_r + 32'h0000_0001;
          end
        end
        S_IWAIT: begin
          if (pat_ok(pat_r, trig_act))
            st_r <= S_FETCH;
        end
        default: st_r <= S_IDLE;
      endcase

      // limit hit and kill zero velocity at once; stop ramps it down
      if (lim_hit && st_r != S_HOME) begin
        target_r <= {VEL_W{1'b0}};
        velocity_o <= {VEL_W{1'b0}};
      end
      if (abort) begin
        target_r <= {VEL_W{1'b0}};
        if (cmd_op_i == `IMS_OP_KILL)
          velocity_o <= {VEL_W{1'b0}};
        if (st_r != S_DECEL)
          st_r <= S_FETCH;
        waiting_o <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/ims_defines.vh
// constants for the indexer motion sequencer
`ifndef IMS_DEFINES_VH
`define IMS_DEFINES_VH
// command opcodes on the host command port
`define IMS_OP_W          4
`define IMS_OP_SEEK_HOME  4'h1
`define IMS_OP_CONT_MODE  4'h2
`define IMS_OP_HOLD_QUEUE 4'h3
`define IMS_OP_CONTINUE   4'h4
`define IMS_OP_VELOCITY   4'h5
`define IMS_OP_ACCEL      4'h6
`define IMS_OP_GO         4'h7
`define IMS_OP_TIME_WAIT  4'h8
`define IMS_OP_INPUT_WAIT 4'h9
`define IMS_OP_LIMIT_DIS  4'hA
`define IMS_OP_STOP       4'hB
`define IMS_OP_KILL       4'hC
// timing: one second of timed wait, in ns and in cycles at 100 MHz
`define IMS_CLK_NS        10
`define IMS_SECOND_NS     1000000000
`define IMS_SECOND_CYC    (`IMS_SECOND_NS / `IMS_CLK_NS)
// cycles between two velocity ramp steps
`define IMS_RAMP_CYC      65536
// trigger input that doubles as a limit by default
`define IMS_LIMIT_TRIG    2
`define IMS_QUEUE_DEPTH   16
`define IMS_QUEUE_AW      4
`endif

// File: verif/ims_asserts.sv
// port assertions for the motion sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ims_defines.vh"
module ims_asserts (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        cmd_valid_i,
  input wire logic [3:0]  cmd_op_i,
  input wire logic        cmd_ready_o,
  input wire logic        cw_limit_n_i,
  input wire logic        step_o,
  input wire logic        dir_o,
  input wire logic [15:0] velocity_o,
  input wire logic [31:0] position_o,
  input wire logic [31:0] home_pos_o,
  input wire logic        waiting_o,
  input wire logic        homed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire take_w = cmd_valid_i && cmd_ready_o;
  wire kill_w = take_w && (cmd_op_i == `IMS_OP_KILL);
  wire abort_w = kill_w || (take_w && (cmd_op_i == `IMS_OP_STOP));
  property p_step_pulse; step_o |=> !step_o; endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("step pulse too wide");
  property p_step_vel;
    step_o |-> $past(velocity_o) != 16'h0 || $past(velocity_o, 2) != 16'h0;
  endproperty
  a_step_vel: assert property (p_step_vel)
    else $error("step without velocity");
  property p_home_latch; $changed(home_pos_o) |-> !$past(homed_o); endproperty
  a_home_latch: assert property (p_home_latch)
    else $error("home position moved after homing");
  property p_homed_still; $rose(homed_o) |-> velocity_o == 16'h0; endproperty
  a_homed_still: assert property (p_homed_still)
    else $error("homed while still moving");
  property p_homed_pos; $rose(homed_o) |-> position_o == 32'h0; endproperty
  a_homed_pos: assert property (p_homed_pos)
    else $error("position not zero after homing");
  property p_kill_zero; kill_w |-> ##[1:3] velocity_o == 16'h0; endproperty
  a_kill_zero: assert property (p_kill_zero)
    else $error("kill left velocity");
  property p_wait_abort;
    waiting_o && abort_w |-> ##[1:2] !waiting_o;
  endproperty
  a_wait_abort: assert property (p_wait_abort)
    else $error("wait not aborted");
  property p_limit_stop;
    dir_o && !cw_limit_n_i && !$past(cw_limit_n_i, 4) |-> !step_o;
  endproperty
  a_limit_stop: assert property (p_limit_stop)
    else $error("step into active limit");
endmodule
bind ims_sequencer ims_asserts u_ims_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i), .cmd_ready_o(cmd_ready_o),
  .cw_limit_n_i(cw_limit_n_i), .step_o(step_o), .dir_o(dir_o),
  .velocity_o(velocity_o), .position_o(position_o),
  .home_pos_o(home_pos_o), .waiting_o(waiting_o), .homed_o(homed_o));
`default_nettype wire

// File: verif/ims_motor_model.sv
// motor, home switch, limit and trigger contacts
`timescale 1ns/100ps
`default_nettype none
module ims_motor_model (
  input  wire logic        clk_i,
  input  wire logic        step_i,
  input  wire logic        dir_i,
  input  wire logic        home_gnd_i,
  input  wire logic        cw_gnd_i,
  input  wire logic [5:0]  trig_gnd_i,
  output logic             home_n_o,
  output logic             cw_limit_n_o,
  output logic [5:0]       trig_n_o,
  output logic [31:0]      steps_o
);
  // grounded contact reads low
  // open contacts sit on their pull-ups
  assign home_n_o = !home_gnd_i;
  assign trig_n_o = ~trig_gnd_i;
  assign cw_limit_n_o = !cw_gnd_i;
  initial steps_o = 32'h0;
  always @(posedge clk_i)
    if (step_i) steps_o <= dir_i ? steps_o + 32'h1 : steps_o - 32'h1;
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the motion sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ims_defines.vh"
module tb_top;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0;
  logic [3:0]  cmd_op_i = 4'h0;
  logic [15:0] cmd_arg_i = 16'h0;
  logic [11:0] cmd_pattern_i = 12'h0;
  logic        home_gnd = 1'b0, cw_gnd = 1'b0;
  logic [5:0]  trig_gnd = 6'h0;
  wire         cmd_ready_o, home_n, cw_n, step_o, dir_o, waiting_o, homed_o;
  wire         moving_o;
  wire  [5:0]  trig_n;
  wire  [15:0] velocity_o;
  wire  [31:0] position_o, home_pos_o, steps;
  int          error_cnt = 0, check_count = 0;
  always #5 clk_i = ~clk_i;
  ims_sequencer #(.SECOND_CYC(10), .RAMP_CYC(16)) u_ims_sequencer (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_arg_i(cmd_arg_i),
    .cmd_pattern_i(cmd_pattern_i), .cmd_ready_o(cmd_ready_o),
    .home_n_i(home_n), .cw_limit_n_i(cw_n), .ccw_limit_n_i(1'b1),
    .trig_n_i(trig_n), .step_o(step_o), .dir_o(dir_o),
    .velocity_o(velocity_o), .position_o(position_o),
    .home_pos_o(home_pos_o), .moving_o(moving_o), .waiting_o(waiting_o),
    .homed_o(homed_o));
  ims_motor_model u_ims_motor_model (
    .clk_i(clk_i), .step_i(step_o), .dir_i(dir_o), .home_gnd_i(home_gnd),
    .cw_gnd_i(cw_gnd), .trig_gnd_i(trig_gnd), .home_n_o(home_n),
    .cw_limit_n_o(cw_n), .trig_n_o(trig_n), .steps_o(steps));
  task automatic check(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: cond = waiting_o === 1'b1;
      1: cond = waiting_o === 1'b0;
      2: cond = homed_o === 1'b1;
      3: cond = velocity_o === 16'h8000;
      5: cond = velocity_o === 16'h4000;
      default: cond = velocity_o === 16'h0;
    endcase
  endfunction
  // bounded wait; a timeout counts and ends the run
  task automatic wait_for(input string nm, input int sel, input int n);
    int i;
    i = 0;
    while (!cond(sel) && i < n) begin
      @(posedge clk_i);
      i++;
    end
    check(nm, cond(sel), 1'b1);
    if (!cond(sel)) final_report();
  endtask
  // valid stays up across back-to-back pushes
  task automatic push(input logic [3:0] op, input logic [15:0] a,
                      input logic [11:0] p);
    int i;
    i = 0;
    cmd_op_i <= op;
    cmd_arg_i <= a;
    cmd_pattern_i <= p;
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    // request stands until ready was seen high at an edge
    while (cmd_ready_o !== 1'b1 && i < 40) begin
      @(posedge clk_i);
      i++;
    end
    if (cmd_ready_o !== 1'b1) begin
      check("ready", cmd_ready_o, 1'b1);
      final_report();
    end
  endtask
  task automatic idle(input int n);
    cmd_valid_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_hold_wait;
    push(`IMS_OP_HOLD_QUEUE, 16'h0, 12'h0);
    push(`IMS_OP_LIMIT_DIS, 16'h3, 12'h0);
    push(`IMS_OP_INPUT_WAIT, 16'h0, 12'h010);
    idle(20);
    check("held", waiting_o, 1'b0);
    push(`IMS_OP_CONTINUE, 16'h0, 12'h0);
    idle(0);
    wait_for("resumed", 0, 20);
    trig_gnd <= 6'h01;
    idle(60);
    check("ignored", waiting_o, 1'b1);
    trig_gnd <= 6'h04;
    wait_for("trig3", 1, 10);
    trig_gnd <= 6'h0;
    idle(4);
  endtask
  task automatic t_abort;
    for (int k = 0; k < 2; k++) begin
      push(`IMS_OP_INPUT_WAIT, 16'h0, 12'h001);
      idle(0);
      wait_for("blocked", 0, 20);
      push(k ? `IMS_OP_KILL : `IMS_OP_STOP, 16'h0, 12'h0);
      idle(0);
      wait_for("aborted", 1, 4);
    end
  endtask
  task automatic t_home;
    logic [31:0] s0;
    push(`IMS_OP_ACCEL, 16'hFFFF, 12'h0);
    push(`IMS_OP_SEEK_HOME, 16'h4000, 12'h001);
    idle(2100);
    check("dir", dir_o, 1'b1);
    check("seek vel", velocity_o, 32'h4000);
    home_gnd <= 1'b1;
    // home reaches the state machine after the synchroniser
    idle(3);
    s0 = steps;
    wait_for("homed", 2, 70000);
    check("home pos", home_pos_o, s0);
    check("zeroed", position_o, 32'h0);
    home_gnd <= 1'b0;
  endtask
  task automatic t_cont;
    logic [31:0] s0;
    push(`IMS_OP_VELOCITY, 16'h8000, 12'h0);
    push(`IMS_OP_CONT_MODE, 16'h0, 12'h0);
    push(`IMS_OP_GO, 16'h0, 12'h0);
    idle(0);
    wait_for("speed", 3, 70000);
    s0 = steps;
    push(`IMS_OP_TIME_WAIT, 16'h1, 12'h0);
    idle(0);
    wait_for("timed", 0, 5);
    idle(9);
    check("still timing", waiting_o, 1'b1);
    wait_for("timed end", 1, 5);
    idle(3000);
    check("held", velocity_o, 32'h8000);
    check("moving", moving_o, 1'b1);
    check("steps", steps > s0 + 32'h3, 1'b1);
    push(`IMS_OP_VELOCITY, 16'h4000, 12'h0);
    push(`IMS_OP_GO, 16'h0, 12'h0);
    idle(0);
    wait_for("new speed", 5, 40);
    check("no stop", moving_o, 1'b1);
    push(`IMS_OP_KILL, 16'h0, 12'h0);
    idle(0);
    wait_for("killed", 4, 4);
    idle(2);
    check("stopped", moving_o, 1'b0);
    push(`IMS_OP_GO, 16'h0, 12'h0);
    idle(0);
    wait_for("restart", 5, 40);
    cw_gnd <= 1'b1;
    wait_for("limit", 4, 10);
    idle(8);
    cw_gnd <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(2);
    t_hold_wait();
    t_abort();
    t_home();
    t_cont();
    final_report();
  end
endmodule
`default_nettype wire
